// *** hw/cfg_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface cfg_if;
  logic                      clock_phase;
  logic                      clock_polarity;
  link_cfg_pkg::link_mode_e  mode;
  logic                      controller;
  modport producer (output clock_phase, output clock_polarity, output mode, output controller);
  modport consumer (input clock_phase, input clock_polarity, input mode, input controller);
endinterface : cfg_if
`default_nettype wire

// *** hw/isolated_link_mode_config.sv ***
//
// Behaviour
// RQ1: Support all four SPI clock modes.
// RQ2: Clock strap captured once per supply power-up.
// RQ3: Never sampled while idle; default phase/polarity one.
// RQ4: Link strap sampled on each idle-to-ready.
// RQ5: Link strap changes ignored until idle again.
// RQ6: Unsampled link mode defaults to bidirectional monitor.
// RQ7: Strap code picks one of four link modes.
// RQ8: Standard mode: controller 2 Mbps, else 1.
// RQ9: Monitor mode controller acts like standard mode.
// RQ10: Monitor peripheral receives 2 Mbps, never returns.
// RQ11: Monitor peripheral enables monitoring, enters listen.
// RQ12: Unidirectional controller transmits only, 4 Mbps.
// RQ13: Unidirectional peripheral receives only, 4 Mbps.
// RQ14: Latency mode returns bits from latching edge.
// RQ15: Latency mode: no return after select low.
// RQ16: Idle state disables most circuitry.
// RQ17: Ready enables all; transfer means active.
// RQ18: Absent interface supply forces peripheral role.
// RQ19: Captured straps kept across supply loss.
// RQ20: Peripheral never sends positive short pulses.
// RQ21: Role select one is controller, zero peripheral.
// RQ22: Controller encodes select edges long, bits short.
// RQ23: Peripheral returns negative for zero, none one.
// RQ24: Peripheral idles pins after inactivity timeout.
// RQ25: Straps arrive decoded, held in internal registers.
// RQ26: Ready-active on pulses; idle after inactivity.
`timescale 1ns/1ns
`default_nettype none
`include "link_cfg_map.svh"
module isolated_link_mode_config #(
  parameter int unsigned IDLE_CYCLES = `IDLE_CYCLES
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // Supply and straps
  input  wire logic        interface_supply,
  input  wire logic [1:0]  clock_mode_strap,
  input  wire logic [1:0]  link_mode_strap,
  input  wire logic        role_select,
  // Wake and link activity
  input  wire logic        wake_detect,
  input  wire logic        rx_pulse,
  // Controller side SPI events
  input  wire logic        cs_rise,
  input  wire logic        cs_fall,
  input  wire logic        cs_level,
  input  wire logic        bit_strobe,
  input  wire logic        bit_value,
  // Peripheral side return request
  input  wire logic        latch_edge,
  input  wire logic        shift_edge,
  input  wire logic        return_value,
  input  wire logic        cs_low_received,
  // Configuration outputs
  output var  logic        clock_phase,
  output var  logic        clock_polarity,
  output var  logic [1:0]  link_mode,
  output var  logic        controller_role,
  output var  logic [2:0]  max_rate_mbps,
  output var  logic        rx_enable,
  output var  logic        tx_enable,
  output var  logic        low_power_monitoring,
  output var  logic        listen,
  // State outputs
  output var  logic        circuits_on,
  output var  logic        state_ready,
  output var  logic        state_active,
  // Peripheral SPI pin idling
  output var  logic        idle_pins,
  output var  logic        idle_cs,
  output var  logic        idle_pico,
  output var  logic        idle_sck,
  // Pulse requests
  output var  link_cfg_pkg::pulse_t long_pulse,
  output var  link_cfg_pkg::pulse_t short_pulse
);
  if (IDLE_CYCLES < 1) begin : g_bad_idle
    $error("IDLE_CYCLES must be at least one");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Role and state
  link_cfg_pkg::link_state_e state;
  link_cfg_pkg::link_state_e next_state;
  logic [31:0]               idle_count;
  logic                      idle_expired;
  logic                      traffic;
  logic                      waking;

  logic role;
  assign role = interface_supply & role_select; // RQ18 RQ21

  assign traffic = rx_pulse | bit_strobe | cs_rise | cs_fall;
  assign idle_expired = (idle_count >= IDLE_CYCLES - 1);
  assign waking = wake_detect | (role & ~cs_level);

  always_comb begin
    next_state = state;
    case (state)
      link_cfg_pkg::st_idle: begin
        if (waking) begin
          next_state = link_cfg_pkg::st_ready;
        end
      end
      link_cfg_pkg::st_ready: begin
        if (traffic) begin
          next_state = link_cfg_pkg::st_active; // RQ26
        end else if (idle_expired && !(role && !cs_level)) begin
          next_state = link_cfg_pkg::st_idle; // RQ26 RQ24
        end
      end
      link_cfg_pkg::st_active: begin
        if (!traffic) begin
          next_state = link_cfg_pkg::st_ready; // RQ26 RQ17
        end
      end
      default: next_state = link_cfg_pkg::st_idle;
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= link_cfg_pkg::st_idle;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      idle_count <= 32'h0;
    end else if (state != link_cfg_pkg::st_ready || traffic) begin
      idle_count <= 32'h0;
    end else if (!idle_expired) begin
      idle_count <= idle_count + 32'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Strap capture
  logic [1:0] clock_code;
  logic [1:0] mode_code;
  logic       clock_taken;
  logic       wake_edge;
  assign wake_edge = (state == link_cfg_pkg::st_idle) && (next_state == link_cfg_pkg::st_ready);

  // Supply loss clears the taken flag but keeps the captured code
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clock_code  <= `CLOCK_MODE_DEFAULT; // RQ3
      clock_taken <= 1'b0;
    end else if (!interface_supply) begin
      clock_taken <= 1'b0; // RQ19
    end else if (!clock_taken && state != link_cfg_pkg::st_idle) begin
      clock_code  <= clock_mode_strap; // RQ2 RQ3 RQ25
      clock_taken <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_code <= `LINK_MODE_DEFAULT; // RQ6
    end else if (wake_edge && interface_supply) begin
      mode_code <= link_mode_strap; // RQ4 RQ5 RQ19 RQ25
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Mode decode
  cfg_if cfg ();
  link_cfg_pkg::link_mode_e mode;

  always_comb begin
    if (mode_code == `STRAP_GND) begin
      mode = link_cfg_pkg::mode_std_bidir; // RQ7
    end else if (mode_code == `STRAP_R20K) begin
      mode = link_cfg_pkg::mode_bidir_monitor;
    end else if (mode_code == `STRAP_R100K) begin
      mode = link_cfg_pkg::mode_unidir_4m;
    end else begin
      mode = link_cfg_pkg::mode_latency_2m;
    end
  end

  // Code order matches mode number: bit 1 polarity, bit 0 phase
  assign cfg.clock_polarity = clock_code[1]; // RQ1
  assign cfg.clock_phase    = clock_code[0]; // RQ1
  assign cfg.mode           = mode;
  assign cfg.controller     = role;

  //////////////////////////////////////////////////////////////////////////////
  // Configuration outputs
  logic monitor_periph;
  assign monitor_periph = (mode == link_cfg_pkg::mode_bidir_monitor) && !role;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clock_phase     <= 1'b1;
      clock_polarity  <= 1'b1;
      link_mode       <= 2'h1;
      controller_role <= 1'b0;
    end else begin
      clock_phase     <= cfg.clock_phase;
      clock_polarity  <= cfg.clock_polarity;
      link_mode       <= mode_code;
      controller_role <= role;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      max_rate_mbps <= 3'h1;
      rx_enable     <= 1'b0;
      tx_enable     <= 1'b0;
    end else begin
      case (mode)
        link_cfg_pkg::mode_std_bidir: begin
          max_rate_mbps <= role ? 3'h2 : 3'h1; // RQ8
          rx_enable     <= 1'b1;
          tx_enable     <= 1'b1;
        end
        link_cfg_pkg::mode_bidir_monitor: begin
          max_rate_mbps <= role ? 3'h2 : 3'h2; // RQ9 RQ10
          rx_enable     <= 1'b1;
          tx_enable     <= role;
        end
        link_cfg_pkg::mode_unidir_4m: begin
          max_rate_mbps <= 3'h4; // RQ12 RQ13
          rx_enable     <= !role;
          tx_enable     <= role;
        end
        default: begin
          max_rate_mbps <= 3'h2; // RQ14
          rx_enable     <= 1'b1;
          tx_enable     <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      low_power_monitoring <= 1'b0;
      listen               <= 1'b0;
    end else begin
      low_power_monitoring <= monitor_periph; // RQ11
      listen               <= monitor_periph;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State and idle pins
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      circuits_on  <= 1'b0;
      state_ready  <= 1'b0;
      state_active <= 1'b0;
    end else begin
      circuits_on  <= (next_state != link_cfg_pkg::st_idle); // RQ16 RQ17
      state_ready  <= (next_state == link_cfg_pkg::st_ready);
      state_active <= (next_state == link_cfg_pkg::st_active);
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      idle_pins <= 1'b1;
      idle_cs   <= 1'b1;
      idle_pico <= 1'b1;
      idle_sck  <= 1'b1;
    end else begin
      idle_pins <= !role && (next_state == link_cfg_pkg::st_idle); // RQ24
      idle_cs   <= 1'b1;
      idle_pico <= 1'b1;
      idle_sck  <= cfg.clock_polarity;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Return bit timing for the peripheral
  logic return_strobe;
  logic enc_enabled;
  assign enc_enabled = (state != link_cfg_pkg::st_idle);

  always_comb begin
    if (mode == link_cfg_pkg::mode_latency_2m) begin
      return_strobe = latch_edge; // RQ14 RQ15
    end else begin
      return_strobe = shift_edge | cs_low_received;
    end
  end

  pulse_encoder encoder (
    .core_clk      (core_clk),
    .sys_rst       (sys_rst),
    .cfg           (cfg),
    .enabled       (enc_enabled),
    .cs_rise       (cs_rise),
    .cs_fall       (cs_fall),
    .bit_strobe    (bit_strobe),
    .bit_value     (bit_value),
    .return_strobe (return_strobe),
    .return_value  (return_value),
    .long_pulse    (long_pulse),
    .short_pulse   (short_pulse)
  );
endmodule : isolated_link_mode_config
`default_nettype wire

// *** hw/link_cfg_map.svh ***
`ifndef LINK_CFG_MAP_SVH
`define LINK_CFG_MAP_SVH
// Strap codes, already decoded from the four pin levels
`define STRAP_GND       2'h0
`define STRAP_R20K      2'h1
`define STRAP_R100K     2'h2
`define STRAP_SUPPLY    2'h3
// Defaults when the straps were never sampled
`define CLOCK_MODE_DEFAULT 2'h3
`define LINK_MODE_DEFAULT  2'h1
// Inactivity time before idle, in microseconds, and its cycle count at 20 MHz
`define CLK_MHZ         20
`define IDLE_TIME_US    5000
`define IDLE_CYCLES     (`IDLE_TIME_US * `CLK_MHZ)
`endif

// *** hw/link_cfg_pkg.sv ***
package link_cfg_pkg;
  typedef enum logic [1:0] {
    st_idle,
    st_ready,
    st_active
  } link_state_e;

  typedef enum logic [1:0] {
    mode_std_bidir,
    mode_bidir_monitor,
    mode_unidir_4m,
    mode_latency_2m
  } link_mode_e;

  typedef enum logic [1:0] {
    pulse_none,
    pulse_pos,
    pulse_neg
  } pulse_t;
endpackage : link_cfg_pkg

// *** hw/pulse_encoder.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "link_cfg_map.svh"
module pulse_encoder (
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          sys_rst,
  // Configuration
  cfg_if.consumer            cfg,
  input  wire logic          enabled,
  // Controller side SPI events
  input  wire logic          cs_rise,
  input  wire logic          cs_fall,
  input  wire logic          bit_strobe,
  input  wire logic          bit_value,
  // Peripheral return request
  input  wire logic          return_strobe,
  input  wire logic          return_value,
  // Pulse requests
  output var  link_cfg_pkg::pulse_t long_pulse,
  output var  link_cfg_pkg::pulse_t short_pulse
);
  logic tx_allowed;

  // Peripheral transmits nothing in monitor or unidirectional mode
  always_comb begin
    if (cfg.controller) begin
      tx_allowed = 1'b1; // RQ9 RQ12
    end else if (cfg.mode == link_cfg_pkg::mode_bidir_monitor || cfg.mode == link_cfg_pkg::mode_unidir_4m) begin
      tx_allowed = 1'b0; // RQ10 RQ13
    end else begin
      tx_allowed = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      long_pulse <= link_cfg_pkg::pulse_none;
    end else if (enabled && cfg.controller && cs_rise) begin
      long_pulse <= link_cfg_pkg::pulse_pos; // RQ22
    end else if (enabled && cfg.controller && cs_fall) begin
      long_pulse <= link_cfg_pkg::pulse_neg; // RQ22
    end else begin
      long_pulse <= link_cfg_pkg::pulse_none;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      short_pulse <= link_cfg_pkg::pulse_none;
    end else if (!enabled || !tx_allowed) begin
      short_pulse <= link_cfg_pkg::pulse_none;
    end else if (cfg.controller) begin
      if (bit_strobe) begin
        short_pulse <= bit_value ? link_cfg_pkg::pulse_pos : link_cfg_pkg::pulse_neg; // RQ22
      end else begin
        short_pulse <= link_cfg_pkg::pulse_none;
      end
    end else if (return_strobe && !return_value) begin
      short_pulse <= link_cfg_pkg::pulse_neg; // RQ23 RQ20
    end else begin
      short_pulse <= link_cfg_pkg::pulse_none;
    end
  end
endmodule : pulse_encoder
`default_nettype wire

// *** tb/isolated_link_mode_config_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module isolated_link_mode_config_bench;
  logic core_clk, sys_rst, interface_supply, role_select, wake_detect, rx_pulse, slow;
  logic cs_rise, cs_fall, cs_level, bit_strobe, bit_value, latch_edge, shift_edge, return_value, cs_low_received;
  logic [1:0] clock_mode_strap, link_mode_strap, link_mode, cm;
  logic clock_phase, clock_polarity, controller_role, rx_enable, tx_enable, low_power_monitoring, listen;
  logic circuits_on, state_ready, state_active, idle_pins, idle_cs, idle_pico, idle_sck;
  logic [2:0] max_rate_mbps;
  link_cfg_pkg::pulse_t long_pulse, short_pulse, exp_q[$];
  int fail_count, total_checks, m, e, n;
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  isolated_link_mode_config #(.IDLE_CYCLES(60)) u_dut (.*);
  remote_end u_far (.core_clk(core_clk), .sys_rst(sys_rst), .short_pulse(short_pulse), .slow(slow), .rx_pulse(rx_pulse));
  task tick;
    @(posedge core_clk);
    #5;
  endtask : tick
  task check(input logic [3:0] seen, input logic [3:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task end_sim;
    if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task wake;
    wake_detect = 1'b1;
    tick;
    wake_detect = 1'b0;
    check(4'(state_ready), 4'h1);
    repeat (2) tick;
    check(4'(link_mode), 4'(m));
  endtask : wake
  task wait_idle;
    n = 0;
    while (circuits_on !== 1'b0 && n < 200) begin
      tick;
      n++;
    end
    if (n == 200) begin
      fail_count++;
      end_sim;
    end
  endtask : wait_idle
  task strobe(input int kind, input logic val);
    {bit_strobe, shift_edge, latch_edge, cs_low_received} = 4'h8 >> kind;
    bit_value = val;
    return_value = val;
    tick;
    {bit_strobe, shift_edge, latch_edge, cs_low_received} = 4'h0;
    repeat (6) tick;
  endtask : strobe
  ////////////////////////////////////////////////////////////
  // Data pulses are compared in order of issue
  always @(posedge core_clk) begin
    #1;
    if (!sys_rst && short_pulse !== link_cfg_pkg::pulse_none) begin
      if (exp_q.size() == 0) check(4'(short_pulse), 4'h0);
      else check(4'(short_pulse), 4'(exp_q.pop_front()));
    end
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    end_sim;
  end
  ////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h6d96cb45));
    {sys_rst, interface_supply, role_select, cs_level} = 4'hf;
    {wake_detect, slow, cs_rise, cs_fall, bit_strobe, bit_value} = 6'h0;
    {latch_edge, shift_edge, return_value, cs_low_received, clock_mode_strap, link_mode_strap} = 8'h0;
    m = 1;
    repeat (8) @(posedge core_clk);
    #5 sys_rst = 1'b0;
    tick;
    check({clock_polarity, clock_phase, link_mode}, 4'hd);
    check(4'(circuits_on), 4'h0);
    cm = 2'($urandom_range(3));
    clock_mode_strap = cm;
    for (m = 0; m < 4; m++) begin
      link_mode_strap = 2'(m);
      wake;
      check({clock_polarity, clock_phase}, 4'(cm));
      clock_mode_strap = 2'($urandom_range(3));
      link_mode_strap = ~2'(m);
      slow = 1'($urandom_range(1));
      {cs_level, cs_fall} = 2'h1;
      tick;
      cs_fall = 1'b0;
      check(4'(long_pulse), 4'(link_cfg_pkg::pulse_neg));
      bit_value = 1'($urandom_range(1));
      exp_q.push_back(bit_value ? link_cfg_pkg::pulse_pos : link_cfg_pkg::pulse_neg);
      strobe(0, bit_value);
      {cs_level, cs_rise} = 2'h3;
      tick;
      cs_rise = 1'b0;
      check(4'(link_mode), 4'(m));
      check({rx_enable, tx_enable}, {2'h0, m != 2, 1'b1});
      check(4'(max_rate_mbps), (m == 2) ? 4'h4 : 4'h2);
      wait_idle;
    end
    interface_supply = 1'b0;
    cm = 2'($urandom_range(3));
    clock_mode_strap = cm;
    repeat (2) tick;
    check(4'(controller_role), 4'h0);
    check(4'(link_mode), 4'h3);
    interface_supply = 1'b1;
    role_select = 1'b0;
    for (m = 0; m < 4; m++) begin
      if (m == 2) continue;
      link_mode_strap = 2'(m);
      wake;
      check({clock_polarity, clock_phase}, 4'(cm));
      check({low_power_monitoring, listen, tx_enable}, (m == 1) ? 4'h6 : 4'h1);
      check(4'(max_rate_mbps), (m == 0) ? 4'h1 : 4'h2);
      for (e = 1; e < 4; e++) begin
        if ((m == 0 && e != 2) || (m == 3 && e == 2)) exp_q.push_back(link_cfg_pkg::pulse_neg);
        strobe(e, 1'b0);
        strobe(e, 1'b1);
      end
      wait_idle;
      repeat (2) tick;
      check({idle_pins, idle_cs, idle_pico, idle_sck}, {3'h7, clock_polarity});
    end
    check(4'(exp_q.size()), 4'h0);
    end_sim;
  end
endmodule : isolated_link_mode_config_bench
bind isolated_link_mode_config link_cfg_checker u_chk (.core_clk(core_clk), .sys_rst(sys_rst),
  .interface_supply(interface_supply), .role_select(role_select), .wake_detect(wake_detect), .rx_pulse(rx_pulse),
  .bit_strobe(bit_strobe), .bit_value(bit_value), .link_mode_strap(link_mode_strap), .link_mode(link_mode),
  .controller_role(controller_role), .rx_enable(rx_enable), .tx_enable(tx_enable), .listen(listen),
  .low_power_monitoring(low_power_monitoring), .circuits_on(circuits_on), .state_ready(state_ready),
  .state_active(state_active), .idle_pins(idle_pins), .idle_cs(idle_cs), .idle_pico(idle_pico),
  .short_pulse(short_pulse));
`default_nettype wire

// *** tb/link_cfg_checker_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
module link_cfg_checker (
  // Clock and reset
  input wire logic                 core_clk,
  input wire logic                 sys_rst,
  // Inputs of the block
  input wire logic                 interface_supply,
  input wire logic                 role_select,
  input wire logic                 wake_detect,
  input wire logic                 rx_pulse,
  input wire logic                 bit_strobe,
  input wire logic                 bit_value,
  input wire logic [1:0]           link_mode_strap,
  // Outputs of the block
  input wire logic [1:0]           link_mode,
  input wire logic                 controller_role,
  input wire logic                 rx_enable,
  input wire logic                 tx_enable,
  input wire logic                 low_power_monitoring,
  input wire logic                 listen,
  input wire logic                 circuits_on,
  input wire logic                 state_ready,
  input wire logic                 state_active,
  input wire logic                 idle_pins,
  input wire logic                 idle_cs,
  input wire logic                 idle_pico,
  input wire link_cfg_pkg::pulse_t short_pulse
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_wake;
    !circuits_on && interface_supply ##1 circuits_on;
  endsequence
  sequence s_bit;
    controller_role && (state_ready || state_active) && bit_strobe;
  endsequence
  a_wake_ready: assert property (!circuits_on && wake_detect |=> circuits_on && state_ready)
    else $error("wake did not reach ready");
  a_mode_capture: assert property (s_wake |=> link_mode == $past(link_mode_strap, 2))
    else $error("link mode not taken from strap on wake");
  a_mode_hold: assert property (circuits_on && $past(circuits_on) && $past(circuits_on, 2) |-> $stable(link_mode))
    else $error("link mode changed outside idle");
  a_supply_role: assert property (!interface_supply |=> !controller_role)
    else $error("controller role without supply");
  a_role_pick: assert property (interface_supply && role_select |=> controller_role)
    else $error("role select one ignored");
  a_bit_short: assert property (s_bit |=> short_pulse == ($past(bit_value) ? link_cfg_pkg::pulse_pos
    : link_cfg_pkg::pulse_neg)) else $error("data bit pulse wrong");
  a_no_pos_return: assert property (!controller_role && $past(!controller_role) |-> short_pulse != link_cfg_pkg::pulse_pos)
    else $error("positive short pulse from peripheral");
  a_traffic_active: assert property (state_ready && rx_enable && rx_pulse |=> state_active)
    else $error("traffic did not make state active");
  a_idle_pins: assert property (!circuits_on && !controller_role && $past(!circuits_on && !controller_role)
    |-> idle_pins && idle_cs && idle_pico) else $error("pins not idled");
  a_monitor_role: assert property ($past(!sys_rst, 2) && $stable(link_mode) && $stable(controller_role)
    && link_mode == 2'h1 && !controller_role |-> low_power_monitoring && listen && !tx_enable)
    else $error("monitor peripheral settings wrong");
endmodule : link_cfg_checker
`default_nettype wire

// *** tb/remote_end.sv ***
`timescale 1ns/1ns
`default_nettype none
module remote_end (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  // From the block, and the reply delay select from the bench
  input  wire link_cfg_pkg::pulse_t short_pulse,
  input  wire logic                 slow,
  // Toward the block
  output var  logic                 rx_pulse
);
  logic [2:0] wait_cnt;
  logic       pend;
  logic [3:0] pattern;
  // Answers each data pulse with rx_pulse taken from a rotating pattern, whatever the pulse's value
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_pulse <= 1'b0;
      pend     <= 1'b0;
      wait_cnt <= 3'h0;
      pattern  <= 4'h6;
    end else begin
      rx_pulse <= 1'b0;
      if (short_pulse != link_cfg_pkg::pulse_none) begin
        pend     <= 1'b1;
        wait_cnt <= slow ? 3'h4 : 3'h0;
        pattern  <= {pattern[2:0], pattern[3]};
      end else if (pend && wait_cnt != 3'h0) begin
        wait_cnt <= wait_cnt - 3'h1;
      end else if (pend) begin
        pend     <= 1'b0;
        rx_pulse <= ~pattern[0];
      end
    end
  end
endmodule : remote_end
`default_nettype wire
